// *** src/escs_pkg.sv ***
// constants for the expandable serial crc slice: rom contents, widths, pin sync layout
// assumes a single 200 MHz clock; all slice pins arrive asynchronous to it
package escs_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned MASK_W = 4;
  localparam int unsigned GROUP_W = 4;

  // clock rate the pin sampling runs at
  localparam int unsigned CLK_MHZ = 200;

  // select codes
  localparam logic [3:0] SEL_NULL = 4'h0;
  localparam logic [3:0] SEL_P48_LO = 4'h1;
  localparam logic [3:0] SEL_P56_B2 = 4'h2;
  localparam logic [3:0] SEL_P56_HI = 4'h3;
  localparam logic [3:0] SEL_P56_B1 = 4'h4;
  localparam logic [3:0] SEL_P48_HI = 4'h5;
  localparam logic [3:0] SEL_P32_HI = 4'h6;
  localparam logic [3:0] SEL_CRC16 = 4'h7;
  localparam logic [3:0] SEL_P56_LO = 4'h8;
  localparam logic [3:0] SEL_P48_MID = 4'h9;
  localparam logic [3:0] SEL_P32_LO = 4'ha;
  localparam logic [3:0] SEL_CCITT = 4'hb;
  localparam logic [3:0] SEL_ETH_HI = 4'hc;
  localparam logic [3:0] SEL_ETH_LO = 4'hd;
  localparam logic [3:0] SEL_RES_HI = 4'he;
  localparam logic [3:0] SEL_RES_LO = 4'hf;

  // feedback taps per select code, bit k gets msb feedback xored in
  localparam logic [15:0] TAPS_NULL = 16'h0000;
  localparam logic [15:0] TAPS_P48_LO = 16'ha105;
  localparam logic [15:0] TAPS_P56_B2 = 16'hf080;
  localparam logic [15:0] TAPS_P56_HI = 16'h8222;
  localparam logic [15:0] TAPS_P56_B1 = 16'h4bca;
  localparam logic [15:0] TAPS_P48_HI = 16'h0018;
  localparam logic [15:0] TAPS_P32_HI = 16'h00a0;
  localparam logic [15:0] TAPS_CRC16 = 16'h8005;
  localparam logic [15:0] TAPS_P56_LO = 16'h2300;
  localparam logic [15:0] TAPS_P48_MID = 16'h00a0;
  localparam logic [15:0] TAPS_P32_LO = 16'h0805;
  localparam logic [15:0] TAPS_CCITT = 16'h1021;
  localparam logic [15:0] TAPS_ETH_HI = 16'h04c1;
  localparam logic [15:0] TAPS_ETH_LO = 16'h1db7;
  localparam logic [15:0] TAPS_RES_HI = 16'h8e09;
  localparam logic [15:0] TAPS_RES_LO = 16'hbaf7;

  // preset masks: mask bit 3 covers register bits 3:0, mask bit 0 covers bits 15:12
  localparam logic [3:0] MASK_ALL = 4'hf;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_P56_LO = 4'h3;

  // reset value of the crc register
  localparam logic [15:0] CRC_RST = 16'h0000;

  // pin sync vector layout
  localparam int unsigned SYNC_W = 12;
  localparam int unsigned PIN_CP = 0;
  localparam int unsigned PIN_DATA = 1;
  localparam int unsigned PIN_GEN = 2;
  localparam int unsigned PIN_SEL = 3;
  localparam int unsigned PIN_CASC = 7;
  localparam int unsigned PIN_FB = 8;
  localparam int unsigned PIN_CLR = 9;
  localparam int unsigned PIN_SET_N = 10;
  localparam int unsigned PIN_FAULT_N = 11;
  localparam logic [11:0] SYNC_RST = 12'hc00;

endpackage : escs_pkg

// *** src/escs_rom.sv ***
// polynomial rom of the crc slice: select code to taps, preset mask and control bits
// assumes a select code that is already synchronised to clk_i
`timescale 1ns/1ps
`default_nettype none

module escs_rom (
  input wire logic [3:0] sel_i,
  output logic [15:0] taps_o,
  output logic [3:0] mask_o,
  output logic invert_o,
  output logic lsb_fb_o
);

  always_comb begin
    taps_o = escs_pkg::TAPS_NULL;
    mask_o = escs_pkg::MASK_ALL;
    invert_o = 1'b0;
    lsb_fb_o = 1'b0;
    unique case (sel_i)
      escs_pkg::SEL_NULL: begin
        mask_o = escs_pkg::MASK_NONE;
      end
      escs_pkg::SEL_P48_LO: taps_o = escs_pkg::TAPS_P48_LO;
      escs_pkg::SEL_P56_B2: taps_o = escs_pkg::TAPS_P56_B2;
      escs_pkg::SEL_P56_HI: taps_o = escs_pkg::TAPS_P56_HI;
      escs_pkg::SEL_P56_B1: taps_o = escs_pkg::TAPS_P56_B1;
      escs_pkg::SEL_P48_HI: taps_o = escs_pkg::TAPS_P48_HI;
      escs_pkg::SEL_P32_HI: taps_o = escs_pkg::TAPS_P32_HI;
      escs_pkg::SEL_CRC16: taps_o = escs_pkg::TAPS_CRC16;
      escs_pkg::SEL_P56_LO: begin
        taps_o = escs_pkg::TAPS_P56_LO;
        mask_o = escs_pkg::MASK_P56_LO;
      end
      escs_pkg::SEL_P48_MID: taps_o = escs_pkg::TAPS_P48_MID;
      escs_pkg::SEL_P32_LO: taps_o = escs_pkg::TAPS_P32_LO;
      escs_pkg::SEL_CCITT: taps_o = escs_pkg::TAPS_CCITT;
      escs_pkg::SEL_ETH_HI: begin
        taps_o = escs_pkg::TAPS_ETH_HI;
        invert_o = 1'b1;
      end
      escs_pkg::SEL_ETH_LO: begin
        taps_o = escs_pkg::TAPS_ETH_LO;
        invert_o = 1'b1;
      end
      escs_pkg::SEL_RES_HI: begin
        taps_o = escs_pkg::TAPS_RES_HI;
        mask_o = escs_pkg::MASK_NONE;
      end
      escs_pkg::SEL_RES_LO: begin
        taps_o = escs_pkg::TAPS_RES_LO;
        mask_o = escs_pkg::MASK_NONE;
        lsb_fb_o = 1'b1;
      end
    endcase
  end

endmodule : escs_rom

`default_nettype wire

// *** src/escs_slice.sv ***
// cascadable 16-bit serial crc generator and checker slice
// assumes slice pins are asynchronous: each passes two flip-flops; the serial clock pin
// must stay high and low for at least four clk_i cycles each
`timescale 1ns/1ps
`default_nettype none

module escs_slice (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic serial_clk_i,
  input wire logic data_i,
  input wire logic check_word_generate_i,
  input wire logic [3:0] poly_select_i,
  input wire logic cascade_in_i,
  input wire logic feedback_in_i,
  input wire logic clear_in_i,
  input wire logic set_in_n_i,
  input wire logic crc_fault_n_i,
  output logic crc_fault_n_o,
  output logic crc_fault_oe_n_o,
  output logic wired_ok_o,
  output logic serial_out_o,
  output logic msb_out_o,
  output logic [15:0] crc_state_o
);

  // pin synchronisers
  logic [escs_pkg::SYNC_W-1:0] pins_raw;
  logic [escs_pkg::SYNC_W-1:0] sync1_ff;
  logic [escs_pkg::SYNC_W-1:0] sync2_ff;

  // synchronised pin levels
  logic cp_s;
  logic data_s;
  logic gen_s;
  logic [3:0] sel_s;
  logic casc_s;
  logic fb_s;
  logic clr_s;
  logic set_n_s;
  logic fault_n_s;

  // edge detect of the serial clock
  logic cp_d_ff;
  logic shift_en;

  // rom outputs
  logic [15:0] taps;
  logic [3:0] mask;
  logic invert;
  logic lsb_fb;

  // crc datapath
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic [15:0] shifted;
  logic [15:0] preset_val;
  logic feedback;
  logic lsb_in;

  // outputs
  logic fault_oe_n_ff;
  logic nxt_fault_oe_n;
  logic serial_out_ff;
  logic nxt_serial_out;
  logic wired_ok_ff;

  assign pins_raw = {crc_fault_n_i, set_in_n_i, clear_in_i, feedback_in_i, cascade_in_i,
                     poly_select_i, check_word_generate_i, data_i, serial_clk_i};

  // two-stage sync of every slice pin
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync1_ff <= escs_pkg::SYNC_RST;
      sync2_ff <= escs_pkg::SYNC_RST;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  assign cp_s = sync2_ff[escs_pkg::PIN_CP];
  assign data_s = sync2_ff[escs_pkg::PIN_DATA];
  assign gen_s = sync2_ff[escs_pkg::PIN_GEN];
  assign sel_s = sync2_ff[escs_pkg::PIN_SEL +: escs_pkg::SEL_W];
  assign casc_s = sync2_ff[escs_pkg::PIN_CASC];
  assign fb_s = sync2_ff[escs_pkg::PIN_FB];
  assign clr_s = sync2_ff[escs_pkg::PIN_CLR];
  assign set_n_s = sync2_ff[escs_pkg::PIN_SET_N];
  assign fault_n_s = sync2_ff[escs_pkg::PIN_FAULT_N];

  // rising edge of the serial clock; starts high, but a clock parked high still gives one rise, as the sync stages reset the clock bit low
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cp_d_ff <= 1'b1;
    end else begin
      cp_d_ff <= cp_s;
    end
  end

  assign shift_en = cp_s & ~cp_d_ff;

  // polynomial rom
  escs_rom u_rom (
    .sel_i(sel_s),
    .taps_o(taps),
    .mask_o(mask),
    .invert_o(invert),
    .lsb_fb_o(lsb_fb)
  );

  // feedback: data against the chain msb, inhibited while the check word is shifted out
  assign feedback = gen_s & (data_s ^ fb_s);
  // lsb source: cascade from the slice below, or feedback on the SEL_RES_LO location only
  assign lsb_in = lsb_fb ? fb_s : casc_s;

  // per-bit shift with rom taps and per-group preset pattern
  genvar gi;
  generate
    for (gi = 0; gi < escs_pkg::REG_W; gi++) begin : g_bit
      if (gi == 0) begin : g_lsb
        assign shifted[gi] = lsb_in ^ (taps[gi] & feedback);
      end else begin : g_upper
        assign shifted[gi] = crc_ff[gi-1] ^ (taps[gi] & feedback);
      end
      // mask bit 3 covers bits 3:0 down to mask bit 0 covering bits 15:12
      assign preset_val[gi] = mask[escs_pkg::MASK_W-1-(gi/escs_pkg::GROUP_W)];
    end
  endgenerate

  // next register value: clear wins over preset, preset over shift
  always_comb begin
    nxt_crc = crc_ff;
    if (clr_s) begin
      nxt_crc = escs_pkg::CRC_RST;
    end else if (!set_n_s) begin
      nxt_crc = preset_val;
    end else if (shift_en) begin
      nxt_crc = shifted;
    end
  end

  // crc register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      crc_ff <= escs_pkg::CRC_RST;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  // fault pin released only when the register will be all zero
  assign nxt_fault_oe_n = (nxt_crc == escs_pkg::CRC_RST);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fault_oe_n_ff <= 1'b1;
    end else begin
      fault_oe_n_ff <= nxt_fault_oe_n;
    end
  end

  // serial output: data while generating, then the check word msb first
  always_comb begin
    if (gen_s) begin
      nxt_serial_out = data_s;
    end else begin
      nxt_serial_out = crc_ff[escs_pkg::REG_W-1] ^ invert;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      serial_out_ff <= 1'b0;
    end else begin
      serial_out_ff <= nxt_serial_out;
    end
  end

  // level seen on the shared fault wire
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wired_ok_ff <= 1'b0;
    end else begin
      wired_ok_ff <= fault_n_s;
    end
  end

  assign crc_fault_n_o = 1'b0;
  assign crc_fault_oe_n_o = fault_oe_n_ff;
  assign wired_ok_o = wired_ok_ff;
  assign serial_out_o = serial_out_ff;
  assign msb_out_o = crc_ff[escs_pkg::REG_W-1];
  assign crc_state_o = crc_ff;

endmodule : escs_slice

`default_nettype wire

// *** verification/escs_slice_monitor.sv ***
// port checker for escs_slice
// assumes pins held steady around each serial clock rise
`timescale 1ns/1ps
`default_nettype none

module escs_slice_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic serial_clk_i,
  input wire logic check_word_generate_i,
  input wire logic [3:0] poly_select_i,
  input wire logic clear_in_i,
  input wire logic set_in_n_i,
  input wire logic crc_fault_oe_n_o,
  input wire logic serial_out_o,
  input wire logic msb_out_o,
  input wire logic [15:0] crc_state_o
);
  logic [2:0] ck_ff;
  logic [1:0] cl_ff;
  logic [1:0] pr_ff;
  logic rise;
  logic idle;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ck_ff <= 3'h4;
      cl_ff <= 2'h0;
      pr_ff <= 2'h3;
    end else begin
      ck_ff <= {ck_ff[1:0], serial_clk_i};
      cl_ff <= {cl_ff[0], clear_in_i};
      pr_ff <= {pr_ff[0], set_in_n_i};
    end
  end

  assign rise = ck_ff[1] & ~ck_ff[2];
  assign idle = !cl_ff[1] && pr_ff[1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  hold_state_a: assert property (!rise && idle |=> $stable(crc_state_o))
    else $error("state moved without shift");
  shift_out_a: assert property (rise && idle && !check_word_generate_i
    |=> crc_state_o[15:1] == $past(crc_state_o[14:0])) else $error("plain shift wrong");
  fault_zero_a: assert property (crc_fault_oe_n_o == (crc_state_o == 16'h0000))
    else $error("fault level wrong");
  msb_tap_a: assert property (msb_out_o == crc_state_o[15])
    else $error("msb output wrong");
  clear_all_a: assert property (cl_ff[1] |=> crc_state_o == 16'h0000)
    else $error("clear failed");
  preset_full_a: assert property (!cl_ff[1] && !pr_ff[1] && poly_select_i inside {4'h7, 4'hb, 4'hc}
    |=> crc_state_o == 16'hffff) else $error("preset not all ones");
  preset_low_a: assert property (!cl_ff[1] && !pr_ff[1] && poly_select_i == 4'h8
    |=> crc_state_o == 16'hff00) else $error("low slice preset wrong");
  preset_zero_a: assert property (!cl_ff[1] && !pr_ff[1] && poly_select_i inside {4'h0, 4'he, 4'hf}
    |=> crc_state_o == 16'h0000) else $error("preset not cleared");
  check_pol_a: assert property (!$past(check_word_generate_i, 3) && poly_select_i == $past(poly_select_i, 4)
    |-> serial_out_o == ($past(msb_out_o) ^ (poly_select_i inside {4'hc, 4'hd}))) else $error("check bit wrong");

  cover property (rise && check_word_generate_i);
  cover property (!pr_ff[1] && poly_select_i == 4'h8);
  cover property (rise && !check_word_generate_i && crc_state_o != 16'h0000);

endmodule : escs_slice_monitor

bind escs_slice escs_slice_monitor u_mon (.clk_i, .nrst_i, .serial_clk_i, .check_word_generate_i,
  .poly_select_i, .clear_in_i, .set_in_n_i, .crc_fault_oe_n_o, .serial_out_o, .msb_out_o, .crc_state_o);

`default_nettype wire

// *** verification/escs_partner.sv ***
// serial source model: one bit per call, own msb fed back
// assumes a single slice, so it is the top of the chain
`timescale 1ns/1ps
`default_nettype none

module escs_partner (
  input wire logic clk_i,
  input wire logic msb_i,
  output logic sclk_o,
  output logic data_o,
  output logic gen_o,
  output logic fb_o
);
  assign fb_o = msb_i;

  initial begin
    sclk_o = 1'b0;
    data_o = 1'b0;
    gen_o = 1'b0;
  end

  task automatic put(input logic b, input logic g);
    @(negedge clk_i);
    data_o = b;
    gen_o = g;
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b0;
    data_o = ~b;
    repeat (4) @(negedge clk_i);
  endtask : put

endmodule : escs_partner

`default_nettype wire

// *** verification/escs_slice_tb_top.sv ***
// self-checking bench for one escs_slice
// assumes escs_partner drives the serial pins
`timescale 1ns/1ps
`default_nettype none

module escs_slice_tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] sel = 4'h0;
  logic clr = 1'b0;
  logic set_n = 1'b1;
  logic inv = 1'b0;
  logic [15:0] m = 16'h0000;
  logic casc = 1'b0;
  logic lfb = 1'b0;
  int num_errors = 0;
  int checks = 0;
  wire logic sclk, dat, gen, fb, fo, foe, wok, so, msb;
  wire logic [15:0] crc;

  escs_slice dut (.clk_i(clk_i), .nrst_i(nrst_i), .serial_clk_i(sclk), .data_i(dat),
    .check_word_generate_i(gen), .poly_select_i(sel), .cascade_in_i(casc), .feedback_in_i(fb),
    .clear_in_i(clr), .set_in_n_i(set_n), .crc_fault_n_i(foe | fo), .crc_fault_n_o(fo),
    .crc_fault_oe_n_o(foe), .wired_ok_o(wok), .serial_out_o(so), .msb_out_o(msb), .crc_state_o(crc));
  escs_partner pm (.clk_i(clk_i), .msb_i(msb), .sclk_o(sclk), .data_o(dat), .gen_o(gen), .fb_o(fb));

  initial forever #2.5 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic finish_test();
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic step(input logic b, input logic g, input logic [15:0] t);
    logic f;
    f = g & (b ^ m[15]);
    m = {m[14:0], lfb ? m[15] : casc} ^ ({16{f}} & t);
    pm.put(b, g);
    chk("crc", crc, m);
    chk("drive", fo, 16'h0000);
    chk("fault", foe, m == 16'h0000);
    chk("wired", wok, m == 16'h0000);
    chk("out", so, g ? dat : m[15] ^ inv);
  endtask : step

  task automatic pulse(input logic c, input logic s);
    @(negedge clk_i);
    clr = c;
    set_n = s;
    repeat (4) @(negedge clk_i);
    clr = 1'b0;
    set_n = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : pulse

  task automatic t_preset();
    logic [3:0] c [8] = '{4'h0, 4'h7, 4'h8, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    logic [15:0] e [8] = '{16'h0, 16'hffff, 16'hff00, 16'hffff, 16'hffff, 16'hffff, 16'h0, 16'h0};
    for (int i = 0; i < 8; i++) begin
      sel = c[i];
      pulse(1'b0, 1'b0);
      chk("preset", crc, e[i]);
      pulse(1'b1, 1'b0);
      chk("clear", crc, 16'h0000);
    end
  endtask : t_preset

  task automatic t_poly(input logic [3:0] code, input logic [15:0] t);
    logic [31:0] w;
    w = 32'hb3c50000;
    sel = code;
    pulse(1'b1, 1'b1);
    m = 16'h0000;
    for (int i = 31; i >= 16; i--) step(w[i], 1'b1, t);
    w[15:0] = m;
    for (int i = 0; i < 16; i++) step(1'b0, 1'b0, t);
    for (int k = 0; k < 2; k++) begin
      pulse(1'b1, 1'b1);
      m = 16'h0000;
      for (int i = 31; i >= 0; i--) step(w[i] ^ (k == 1 && i == 9), 1'b1, t);
      chk("verdict", foe, k == 0);
    end
  endtask : t_poly

  task automatic t_misc();
    sel = 4'h0;
    pulse(1'b1, 1'b1);
    m = 16'h0000;
    step(1'b1, 1'b1, 16'h0000);
    chk("null", crc, 16'h0000);
    sel = 4'hd;
    pulse(1'b0, 1'b0);
    m = 16'hffff;
    inv = 1'b1;
    step(1'b0, 1'b0, 16'h0000);
    step(1'b0, 1'b0, 16'h0000);
    chk("inv", so, 16'h0000);
    inv = 1'b0;
  endtask : t_misc

  task automatic t_lsb();
    sel = 4'hf;
    pulse(1'b1, 1'b1);
    m = 16'h0000;
    lfb = 1'b1;
    for (int i = 0; i < 6; i++) step(i[0], 1'b1, 16'hbaf7);
    lfb = 1'b0;
    sel = 4'h7;
    casc = 1'b1;
    for (int i = 0; i < 3; i++) step(1'b0, 1'b0, 16'h8005);
    casc = 1'b0;
    sel = 4'hd;
    pulse(1'b1, 1'b1);
    m = 16'h0000;
    for (int i = 0; i < 4; i++) step(1'b1, 1'b1, 16'h1db7);
  endtask : t_lsb

  initial begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    t_preset();
    t_poly(4'h7, 16'h8005);
    t_poly(4'hb, 16'h1021);
    t_misc();
    t_lsb();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    finish_test();
  end

endmodule : escs_slice_tb_top

`default_nettype wire
